/* scsp_device.sv */
// Purpose: device end of the serial control/status port
// Assumes: link pins and monitor inputs are asynchronous to SYS_CLK
// Notes: eight 28-bit base registers, low nibble carries address and rw
// Operation
// - power-up reset loads every register default
// - divider reset: request a, request b, trigger
// - sync: request a, request b, trigger after divider
// - host sends both sequences in separate writes
// - wrong order gives unknown; power-down rearms sync
// - zeros leave divider bits; sync writes zeros
// - completed sync starts reference pulse generation
// - host clears pending interrupts before monitoring
// - status bits show calibration, lock, input
// - input flag follows three feedback edges
// - lock debounced until stable, then drops immediately
// - lock or input change sets sticky bit
// - interrupt pin low on enabled pending bit
// - writing one clears bit, pin releases
// - data output undriven by default and writing
// - frame starts at rising edge with enable low
// - host shifts 32 bits MSB first
// - early enable rise discards word, no write
// - enable rise after 32nd fall executes word
// - low nibble: three address bits, rw bit
// - next frame shifts 32 read bits out
// - enable rise ends read, output undriven
//
// Added by the designer: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
module scsp_device
  import scsp_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RESET,
  scsp_if.device LINK,
  input wire logic REF_CLK,
  input wire logic VCXO_CLK,
  input wire logic VCXO_CTRL_IN_RANGE,
  input wire logic CAL_DONE,
  output logic DIV_RESET,
  output logic REF_SYNC,
  output logic REF_PULSE_EN,
  output logic REF_UNKNOWN
);
  import scsp_pkg::*;

  logic sck_s, le_n_s, mosi_s, ref_s, vcxo_s, lock_ok_s, cal_s;
  logic sck_p_q, le_p_q, ref_p_q, vcxo_p_q;
  scsp_sync #(.W(7), .INIT(7'h02)) u_sync (
    .clk(SYS_CLK),
    .rst(RESET),
    .d({CAL_DONE, VCXO_CTRL_IN_RANGE, VCXO_CLK, REF_CLK, LINK.mosi,
        LINK.latch_enable_n, LINK.serial_clock}),
    .q({cal_s, lock_ok_s, vcxo_s, ref_s, mosi_s, le_n_s, sck_s})
  );

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      sck_p_q <= 1'b0;
      le_p_q <= 1'b1;
      ref_p_q <= 1'b0;
      vcxo_p_q <= 1'b0;
    end else begin
      sck_p_q <= sck_s;
      le_p_q <= le_n_s;
      ref_p_q <= ref_s;
      vcxo_p_q <= vcxo_s;
    end
  end

  logic rise, fall, le_rise, ref_edge, vcxo_edge;
  assign rise = sck_s & ~sck_p_q;
  assign fall = ~sck_s & sck_p_q;
  assign le_rise = le_n_s & ~le_p_q;
  assign ref_edge = ref_s & ~ref_p_q;
  assign vcxo_edge = vcxo_s & ~vcxo_p_q;

  // register file and sequence state
  logic [27:0] regs_q [8];
  logic [27:0] regs_d [8];
  logic div_a_q, div_a_d, div_b_q, div_b_d, div_done_q, div_done_d;
  logic sync_a_q, sync_a_d, sync_b_q, sync_b_d;
  logic ref_on_q, ref_on_d, unk_q, unk_d;
  logic div_pls_q, div_pls_d, ref_pls_q, ref_pls_d;
  logic [1:0] int_q, int_d;
  logic irq_n_q, irq_n_d;
  logic wr_en_q, wr_en_d;
  logic [31:0] wr_word_q, wr_word_d;
  logic cal_q, lock_q, input_q;

  // serial shifter state
  logic active_q, active_d, rd_mode_q, rd_mode_d, rd_pend_q, rd_pend_d;
  logic [5:0] rcnt_q, rcnt_d, fcnt_q, fcnt_d;
  logic [31:0] sh_q, sh_d, rd_sh_q, rd_sh_d, rd_word;
  logic miso_q, miso_d, oe_q, oe_d;

  always_comb begin
    rd_word = {regs_q[sh_q[2:0]], 4'h0};
    case (sh_q[2:0])
      BASE_CTRL_A: begin
        rd_word = {regs_q[BASE_CTRL_A], 4'h0};
        rd_word[POS_SYNC_REQ_A] = sync_a_q;
        rd_word[POS_DIV_REQ_A] = div_a_q;
      end
      BASE_CTRL_B: begin
        rd_word = {regs_q[BASE_CTRL_B], 4'h0};
        rd_word[POS_DIV_REQ_B] = div_b_q;
        rd_word[POS_SYNC_REQ_B] = sync_b_q;
        rd_word[POS_DIV_TRIG] = 1'b0;
        rd_word[POS_SYNC_TRIG] = 1'b0;
      end
      BASE_STATUS: begin
        rd_word = 32'h0;
        rd_word[POS_CAL] = cal_q;
        rd_word[POS_LOCK] = lock_q;
        rd_word[POS_INPUT] = input_q;
        rd_word[POS_EN0+1:POS_EN0] = regs_q[BASE_STATUS][POS_EN0-3:POS_EN0-4];
        rd_word[POS_INT0+1:POS_INT0] = int_q;
      end
      default: rd_word = {regs_q[sh_q[2:0]], 4'h0};
    endcase
  end

  always_comb begin
    active_d = active_q;
    rd_mode_d = rd_mode_q;
    rd_pend_d = rd_pend_q;
    rcnt_d = rcnt_q;
    fcnt_d = fcnt_q;
    sh_d = sh_q;
    rd_sh_d = rd_sh_q;
    miso_d = miso_q;
    oe_d = oe_q;
    wr_en_d = 1'b0;
    wr_word_d = wr_word_q;
    if (le_n_s) begin
      active_d = 1'b0;
      oe_d = 1'b0;
      if (le_rise && active_q) begin
        if (rd_mode_q) begin
          rd_pend_d = 1'b0;
        end else if (rcnt_q == WORD_BITS && fcnt_q == WORD_BITS) begin
          if (sh_q[POS_RW]) begin
            rd_pend_d = 1'b1;
            rd_sh_d = rd_word;
          end else begin
            wr_en_d = 1'b1;
            wr_word_d = sh_q;
          end
        end
        // any other count: word dropped
      end
    end else begin
      if (rise) begin
        sh_d = {sh_q[30:0], mosi_s};
        if (!active_q) begin
          active_d = 1'b1;
          rd_mode_d = rd_pend_q;
          rcnt_d = 6'h01;
          fcnt_d = 6'h00;
          oe_d = rd_pend_q;
        end else if (rcnt_q != 6'h3f) begin
          rcnt_d = rcnt_q + 6'h01;
        end
        if ((!active_q && rd_pend_q) || (active_q && rd_mode_q)) begin
          miso_d = rd_sh_q[31];
          rd_sh_d = {rd_sh_q[30:0], 1'b0};
        end
      end
      if (fall && active_q && fcnt_q != 6'h3f) begin
        fcnt_d = fcnt_q + 6'h01;
      end
    end
  end

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      active_q <= 1'b0;
      rd_mode_q <= 1'b0;
      rd_pend_q <= 1'b0;
      rcnt_q <= 6'h00;
      fcnt_q <= 6'h00;
      sh_q <= 32'h0;
      rd_sh_q <= 32'h0;
      miso_q <= 1'b0;
      oe_q <= 1'b0;
      wr_en_q <= 1'b0;
      wr_word_q <= 32'h0;
    end else begin
      active_q <= active_d;
      rd_mode_q <= rd_mode_d;
      rd_pend_q <= rd_pend_d;
      rcnt_q <= rcnt_d;
      fcnt_q <= fcnt_d;
      sh_q <= sh_d;
      rd_sh_q <= rd_sh_d;
      miso_q <= miso_d;
      oe_q <= oe_d;
      wr_en_q <= wr_en_d;
      wr_word_q <= wr_word_d;
    end
  end

  assign LINK.miso_o = miso_q;
  assign LINK.miso_oe = oe_q;

  // monitors
  logic [1:0] idle_cnt_q, idle_cnt_d, act_cnt_q, act_cnt_d;
  logic ref_seen_q, ref_seen_d, input_d, lock_d, stable_q, stable_d;
  logic [7:0] deb_q, deb_d;
  logic cal_d;

  always_comb begin
    ref_seen_d = ref_seen_q | ref_edge;
    idle_cnt_d = idle_cnt_q;
    act_cnt_d = act_cnt_q;
    input_d = input_q;
    cal_d = cal_s;
    if (vcxo_edge) begin
      ref_seen_d = 1'b0;
      if (ref_seen_q || ref_edge) begin
        idle_cnt_d = 2'h0;
        act_cnt_d = (act_cnt_q == LOS_EDGES) ? act_cnt_q : act_cnt_q + 2'h1;
      end else begin
        act_cnt_d = 2'h0;
        idle_cnt_d = (idle_cnt_q == LOS_EDGES) ? idle_cnt_q
                                               : idle_cnt_q + 2'h1;
      end
      if (act_cnt_d == LOS_EDGES) input_d = 1'b1;
      if (idle_cnt_d == LOS_EDGES) input_d = 1'b0;
    end
    lock_d = lock_q;
    stable_d = stable_q;
    deb_d = deb_q;
    if (!lock_ok_s) begin
      lock_d = 1'b0;
      deb_d = 8'h00;
    end else if (stable_q) begin
      lock_d = 1'b1;
    end else if (deb_q == LOCK_DEB_CYC) begin
      lock_d = 1'b1;
      stable_d = 1'b1;
    end else begin
      deb_d = deb_q + 8'h01;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      ref_seen_q <= 1'b0;
      idle_cnt_q <= 2'h0;
      act_cnt_q <= 2'h0;
      input_q <= 1'b0;
      lock_q <= 1'b0;
      stable_q <= 1'b0;
      deb_q <= 8'h00;
      cal_q <= 1'b0;
    end else begin
      ref_seen_q <= ref_seen_d;
      idle_cnt_q <= idle_cnt_d;
      act_cnt_q <= act_cnt_d;
      input_q <= input_d;
      lock_q <= lock_d;
      stable_q <= stable_d;
      deb_q <= deb_d;
      cal_q <= cal_d;
    end
  end

  // register writes, sequences and interrupt bits
  logic [31:0] w;
  logic [2:0] base;
  logic div_bits, pwr_dn;
  always_comb begin
    w = wr_word_q;
    base = w[2:0];
    div_bits = (base == BASE_CTRL_A && w[POS_DIV_REQ_A]) ||
               (base == BASE_CTRL_B &&
                (w[POS_DIV_REQ_B] || w[POS_DIV_TRIG]));
    regs_d = regs_q;
    div_a_d = div_a_q;
    div_b_d = div_b_q;
    div_done_d = div_done_q;
    sync_a_d = sync_a_q;
    sync_b_d = sync_b_q;
    ref_on_d = ref_on_q;
    unk_d = unk_q;
    div_pls_d = 1'b0;
    ref_pls_d = 1'b0;
    int_d = int_q;
    if (wr_en_q) begin
      regs_d[base] = w[31:4];
      if (base == BASE_STATUS) begin
        int_d = int_q & ~w[POS_INT0+1:POS_INT0];
      end
      // ones advance a sequence, zeros leave it
      if (base == BASE_CTRL_A && w[POS_DIV_REQ_A]) div_a_d = 1'b1;
      if (base == BASE_CTRL_B && w[POS_DIV_REQ_B] && div_a_q) begin
        div_b_d = 1'b1;
      end
      if (base == BASE_CTRL_B && w[POS_DIV_TRIG] && div_b_q) begin
        div_a_d = 1'b0;
        div_b_d = 1'b0;
        div_done_d = 1'b1;
        div_pls_d = 1'b1;
        if (sync_a_q) unk_d = 1'b1;
      end
      if (!div_bits) begin
        if (base == BASE_CTRL_A && w[POS_SYNC_REQ_A]) sync_a_d = 1'b1;
        if (base == BASE_CTRL_B && w[POS_SYNC_REQ_B] && sync_a_q) begin
          sync_b_d = 1'b1;
        end
        if (base == BASE_CTRL_B && w[POS_SYNC_TRIG] && sync_b_q) begin
          sync_a_d = 1'b0;
          sync_b_d = 1'b0;
          if (div_done_q && !unk_q) begin
            ref_pls_d = 1'b1;
            ref_on_d = 1'b1;
          end else begin
            unk_d = 1'b1;
          end
        end
      end
    end
    pwr_dn = regs_d[BASE_CTRL_B][POS_PWR_DN-4];
    if (pwr_dn) begin
      ref_on_d = 1'b0;
      unk_d = 1'b0;
      ref_pls_d = 1'b0;
    end
    // set wins over a clear in the same cycle
    if (lock_d != lock_q) int_d[1] = 1'b1;
    if (input_d != input_q) int_d[0] = 1'b1;
    irq_n_d = ~|(int_d &
      regs_d[BASE_STATUS][POS_EN0-3:POS_EN0-4]);
  end

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      for (int i = 0; i < 8; i++) begin
        regs_q[i] <= REG_RESET;
      end
      div_a_q <= 1'b0;
      div_b_q <= 1'b0;
      div_done_q <= 1'b0;
      sync_a_q <= 1'b0;
      sync_b_q <= 1'b0;
      ref_on_q <= 1'b0;
      unk_q <= 1'b0;
      div_pls_q <= 1'b0;
      ref_pls_q <= 1'b0;
      int_q <= INT_RESET;
      irq_n_q <= 1'b1;
    end else begin
      regs_q <= regs_d;
      div_a_q <= div_a_d;
      div_b_q <= div_b_d;
      div_done_q <= div_done_d;
      sync_a_q <= sync_a_d;
      sync_b_q <= sync_b_d;
      ref_on_q <= ref_on_d;
      unk_q <= unk_d;
      div_pls_q <= div_pls_d;
      ref_pls_q <= ref_pls_d;
      int_q <= int_d;
      irq_n_q <= irq_n_d;
    end
  end

  assign LINK.irq_out_n = irq_n_q;
  assign DIV_RESET = div_pls_q;
  assign REF_SYNC = ref_pls_q;
  assign REF_PULSE_EN = ref_on_q;
  assign REF_UNKNOWN = unk_q;
endmodule

/* scsp_pkg.sv */
// Purpose: shared constants and types of the serial control/status port
// Assumes: SYS_CLK at 10 MHz on both ends
// Notes: register layout of the control, status and host-side registers
package scsp_pkg;
  localparam int SYS_CLK_NS = 100;
  // serial word framing
  localparam logic [5:0] WORD_BITS = 6'h20;
  localparam int POS_RW = 3;
  // base addresses that carry sequence and status fields
  localparam logic [2:0] BASE_CTRL_A = 3'h1;
  localparam logic [2:0] BASE_STATUS = 3'h2;
  localparam logic [2:0] BASE_CTRL_B = 3'h3;
  // base CTRL_A fields
  localparam int POS_SYNC_REQ_A = 31;
  localparam int POS_DIV_REQ_A = 30;
  // base CTRL_B fields
  localparam int POS_DIV_REQ_B = 31;
  localparam int POS_SYNC_REQ_B = 30;
  localparam int POS_DIV_TRIG = 29;
  localparam int POS_SYNC_TRIG = 28;
  localparam int POS_PWR_DN = 27;
  // base STATUS fields
  localparam int POS_CAL = 30;
  localparam int POS_LOCK = 29;
  localparam int POS_INPUT = 28;
  localparam int POS_EN0 = 8;
  localparam int POS_INT0 = 4;
  // reset values
  localparam logic [27:0] REG_RESET = 28'h0000000;
  localparam logic [1:0] INT_RESET = 2'h0;
  // monitors
  localparam logic [1:0] LOS_EDGES = 2'h3;
  localparam int LOCK_DEBOUNCE_NS = 1000;
  localparam int LOCK_DEB_CYC_I =
    (LOCK_DEBOUNCE_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam logic [7:0] LOCK_DEB_CYC = 8'(LOCK_DEB_CYC_I);
  // host serial clock half period
  localparam int SCLK_HALF_NS = 800;
  localparam int SCLK_HALF_I = SCLK_HALF_NS / SYS_CLK_NS;
  localparam logic [3:0] SCLK_HALF = 4'(SCLK_HALF_I);
  // host register offsets
  localparam logic [3:0] HOST_TX = 4'h0;
  localparam logic [3:0] HOST_CTRL = 4'h4;
  localparam logic [3:0] HOST_STAT = 4'h8;
  localparam logic [3:0] HOST_RX = 4'hc;
  localparam int POS_GO = 0;
  localparam int POS_CAPTURE = 1;
  typedef enum logic [2:0] {
    HS_IDLE = 3'h0,
    HS_SETUP = 3'h1,
    HS_HIGH = 3'h3,
    HS_LOW = 3'h2,
    HS_FIN = 3'h6
  } scsp_hstate_t;
endpackage

/* scsp_if.sv */
// Purpose: four-wire serial link plus active-low interrupt wire
// Assumes: data output has a pull-up on the board
// Notes: the wire level of the data output is resolved here
`timescale 1ns/1ps
interface scsp_if;
  logic serial_clock;
  logic latch_enable_n;
  logic mosi;
  logic miso_o;
  logic miso_oe;
  logic miso;
  logic irq_out_n;
  // pull-up holds the line high while undriven
  assign miso = miso_oe ? miso_o : 1'b1;
  modport device (
    input serial_clock, latch_enable_n, mosi,
    output miso_o, miso_oe, irq_out_n
  );
  modport host (
    output serial_clock, latch_enable_n, mosi,
    input miso, irq_out_n
  );
endinterface

/* scsp_sync.sv */
// Purpose: two-flop synchroniser for a vector of independent levels
// Assumes: each bit is a slow level, no bus coherence needed
// Notes: INIT sets the reset level of both stages
`timescale 1ns/1ps
module scsp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= INIT;
      q <= INIT;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

/* scsp_host.sv */
// Purpose: serial master end, driven by software over AHB-Lite
// Assumes: one frame per command, software orders the sequences
// Notes: serial clock is SYS_CLK divided, half period SCLK_HALF cycles
`timescale 1ns/1ps
module scsp_host
  import scsp_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RESET,
  scsp_if.host LINK,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP
);
  import scsp_pkg::*;

  logic miso_s, irq_n_s;
  scsp_sync #(.W(2), .INIT(2'h3)) u_sync (
    .clk(SYS_CLK),
    .rst(RESET),
    .d({LINK.irq_out_n, LINK.miso}),
    .q({irq_n_s, miso_s})
  );

  scsp_hstate_t st_q, st_d;
  logic [3:0] tmr_q, tmr_d;
  logic [5:0] cnt_q, cnt_d;
  logic [31:0] tx_q, tx_d, sh_q, sh_d, rx_q, rx_d, rdata_q, rdata_d;
  logic sclk_q, sclk_d, le_n_q, le_n_d, mosi_q, mosi_d;
  logic wr_pend_q, wr_pend_d;
  logic [3:0] wr_addr_q, wr_addr_d;
  logic go, capture, tdone;

  always_comb begin
    wr_pend_d = HSEL && HREADY && HTRANS[1] && HWRITE;
    wr_addr_d = HADDR[3:0];
    rdata_d = rdata_q;
    if (HSEL && HREADY && HTRANS[1] && !HWRITE) begin
      case (HADDR[3:0])
        HOST_TX: rdata_d = tx_q;
        HOST_STAT: rdata_d = {30'h0, ~irq_n_s, st_q != HS_IDLE};
        HOST_RX: rdata_d = rx_q;
        default: rdata_d = 32'h0;
      endcase
    end
    tx_d = tx_q;
    go = 1'b0;
    capture = 1'b0;
    if (wr_pend_q && wr_addr_q == HOST_TX) tx_d = HWDATA;
    if (wr_pend_q && wr_addr_q == HOST_CTRL) begin
      go = HWDATA[POS_GO];
      capture = HWDATA[POS_CAPTURE];
    end
    st_d = st_q;
    tmr_d = tmr_q + 4'h1;
    tdone = (tmr_q == SCLK_HALF - 4'h1);
    cnt_d = cnt_q;
    sh_d = sh_q;
    rx_d = rx_q;
    sclk_d = sclk_q;
    le_n_d = le_n_q;
    mosi_d = mosi_q;
    if (tdone) tmr_d = 4'h0;
    case (st_q)
      HS_IDLE: begin
        tmr_d = 4'h0;
        if (go || capture) begin
          // read-out frames send zeros
          sh_d = capture ? 32'h0 : tx_q;
          mosi_d = capture ? 1'b0 : tx_q[31];
          le_n_d = 1'b0;
          cnt_d = 6'h00;
          st_d = HS_SETUP;
        end
      end
      HS_SETUP: begin
        if (tdone) begin
          sclk_d = 1'b1;
          st_d = HS_HIGH;
        end
      end
      HS_HIGH: begin
        if (tdone) begin
          sclk_d = 1'b0;
          rx_d = {rx_q[30:0], miso_s};
          sh_d = {sh_q[30:0], 1'b0};
          mosi_d = sh_q[30];
          cnt_d = cnt_q + 6'h01;
          st_d = HS_LOW;
        end
      end
      HS_LOW: begin
        if (tdone) begin
          if (cnt_q == WORD_BITS) begin
            le_n_d = 1'b1; // one word per frame
            st_d = HS_FIN;
          end else begin
            sclk_d = 1'b1;
            st_d = HS_HIGH;
          end
        end
      end
      HS_FIN: begin
        if (tdone) st_d = HS_IDLE;
      end
      default: st_d = HS_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      st_q <= HS_IDLE;
      tmr_q <= 4'h0;
      cnt_q <= 6'h00;
      tx_q <= 32'h0;
      sh_q <= 32'h0;
      rx_q <= 32'h0;
      rdata_q <= 32'h0;
      sclk_q <= 1'b0;
      le_n_q <= 1'b1;
      mosi_q <= 1'b0;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 4'h0;
    end else begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      cnt_q <= cnt_d;
      tx_q <= tx_d;
      sh_q <= sh_d;
      rx_q <= rx_d;
      rdata_q <= rdata_d;
      sclk_q <= sclk_d;
      le_n_q <= le_n_d;
      mosi_q <= mosi_d;
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
    end
  end

  assign LINK.serial_clock = sclk_q;
  assign LINK.latch_enable_n = le_n_q;
  assign LINK.mosi = mosi_q;
  assign HRDATA = rdata_q;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
endmodule

/* scsp_link_sva.sv */
// Purpose: wire checks on the serial link between the two ends
// Assumes: host half period of eight SYS_CLK cycles
// Notes: helper logic decodes frames seen on the wires
`timescale 1ns/1ps
module scsp_link_sva (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic serial_clock,
  input wire logic latch_enable_n,
  input wire logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe,
  input wire logic miso,
  input wire logic irq_out_n
);
  logic sck_q, sck_d, le_q, le_d, rd_q, rd_d, wr_q, wr_d, b3_q, b3_d;
  logic [5:0] cnt_q, cnt_d;
  logic [4:0] age_q, age_d;
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RESET);
  always_comb begin
    sck_d = serial_clock;
    le_d = latch_enable_n;
    cnt_d = latch_enable_n ? 6'h00 : cnt_q;
    b3_d = b3_q;
    rd_d = rd_q;
    wr_d = wr_q;
    age_d = (age_q == 5'h1f) ? age_q : age_q + 5'h01;
    if (!latch_enable_n && serial_clock && !sck_q) begin
      cnt_d = cnt_q + 6'h01;
      // bit 3 is the 29th bit shifted
      if (cnt_q == 6'h1c) b3_d = mosi;
    end
    if (latch_enable_n && !le_q) begin
      age_d = 5'h00;
      rd_d = (cnt_q == 6'h20) && b3_q;
      wr_d = wr_q || ((cnt_q == 6'h20) && !b3_q);
    end
  end
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      sck_q <= 1'b0;
      le_q <= 1'b1;
      cnt_q <= 6'h00;
      b3_q <= 1'b0;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      age_q <= 5'h1f;
    end else begin
      sck_q <= sck_d;
      le_q <= le_d;
      cnt_q <= cnt_d;
      b3_q <= b3_d;
      rd_q <= rd_d;
      wr_q <= wr_d;
      age_q <= age_d;
    end
  end
  a_idle_undriven:
    assert property (latch_enable_n [*8] |-> !miso_oe && miso)
    else $error("data out driven while idle");
  a_drive_needs_read:
    assert property (miso_oe && !latch_enable_n |-> rd_q)
    else $error("data out driven without read request");
  a_first_bit_edge:
    assert property ($rose(miso_oe) |-> !latch_enable_n && cnt_q == 6'h01)
    else $error("data out not started at first rising edge");
  a_bit_held_low:
    assert property (miso_oe && !serial_clock && !sck_q |-> $stable(miso_o))
    else $error("read bit changed while clock low");
  a_drop_on_latch:
    assert property ($rose(latch_enable_n) |-> ##[1:6] !miso_oe)
    else $error("data out not released after latch rise");
  a_release_cause:
    assert property ($fell(miso_oe) |-> latch_enable_n)
    else $error("data out released with latch low");
  a_irq_needs_write:
    assert property (!irq_out_n |-> wr_q)
    else $error("interrupt low before any enable write");
  a_irq_release:
    assert property ($rose(irq_out_n) |-> age_q < 5'h14)
    else $error("interrupt released without a write");
endmodule

/* tb_serial_control_status_port.sv */
// Purpose: self-checking bench, host and device joined by the link
// Assumes: a second device is driven bit by bit from the bench
// Notes: registers reached over AHB-Lite through the host end
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; \
  if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module tb_serial_control_status_port;
  import scsp_pkg::*;
  logic sys_clk = 1'b0, reset = 1'b1, vcxo = 1'b0, ref_clk = 1'b0;
  logic ref_on = 1'b0, in_range = 1'b0, cal = 1'b0;
  logic hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, got, sh, last_w;
  logic div_rst, ref_sync, pulse_en, ref_unk;
  int bad_count = 0, cmp_count = 0, cyc = 0, n_div = 0, n_sync = 0;
  scsp_if link();
  scsp_if link2();
  scsp_device scsp_device_i(.SYS_CLK(sys_clk), .RESET(reset), .LINK(link),
    .REF_CLK(ref_clk), .VCXO_CLK(vcxo), .VCXO_CTRL_IN_RANGE(in_range),
    .CAL_DONE(cal), .DIV_RESET(div_rst), .REF_SYNC(ref_sync),
    .REF_PULSE_EN(pulse_en), .REF_UNKNOWN(ref_unk));
  scsp_device scsp_device_2_i(.SYS_CLK(sys_clk), .RESET(reset),
    .LINK(link2), .REF_CLK(ref_clk), .VCXO_CLK(vcxo),
    .VCXO_CTRL_IN_RANGE(in_range), .CAL_DONE(cal), .DIV_RESET(),
    .REF_SYNC(), .REF_PULSE_EN(), .REF_UNKNOWN());
  scsp_host scsp_host_i(.SYS_CLK(sys_clk), .RESET(reset), .LINK(link),
    .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp));
  scsp_link_sva scsp_link_sva_i(.SYS_CLK(sys_clk), .RESET(reset),
    .serial_clock(link.serial_clock), .latch_enable_n(link.latch_enable_n),
    .mosi(link.mosi), .miso_o(link.miso_o), .miso_oe(link.miso_oe),
    .miso(link.miso), .irq_out_n(link.irq_out_n));
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  // feedback clock of 800 ns, reference gated by ref_on
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    vcxo <= cyc[2];
    ref_clk <= ref_on & cyc[1];
    if (div_rst === 1'b1) n_div <= n_div + 1;
    if (ref_sync === 1'b1) n_sync <= n_sync + 1;
    if (cyc == 60000) begin
      bad_count++;
      stop_test();
    end
  end
  always @(posedge link.serial_clock) begin
    if (!link.latch_enable_n) sh <= {sh[30:0], link.mosi};
  end
  always @(posedge link.latch_enable_n) last_w <= sh;
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic ahb(input logic w, input logic [3:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {28'h0, a};
    hwrite <= w;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic frame(input logic [31:0] w, input logic [1:0] op);
    ahb(1'b1, HOST_TX, w);
    ahb(1'b1, HOST_CTRL, {30'h0, op});
    @(posedge sys_clk);
    do ahb(1'b0, HOST_STAT, 32'h0); while (rd[0] !== 1'b0);
  endtask
  task automatic wr(input logic [2:0] b, input logic [27:0] d);
    frame({d, 1'b0, b}, 2'h1);
  endtask
  task automatic rdreg(input logic [2:0] b);
    frame({28'h0, 1'b1, b}, 2'h1);
    frame(32'h0, 2'h2);
    ahb(1'b0, HOST_RX, 32'h0);
  endtask
  // bit-level frame on the second link, n bits then latch rise
  task automatic bb(input logic [31:0] w, input int n);
    link2.latch_enable_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      link2.mosi <= w[31-i];
      repeat (4) @(posedge sys_clk);
      link2.serial_clock <= 1'b1;
      repeat (4) @(posedge sys_clk);
      got = {got[30:0], link2.miso};
      link2.serial_clock <= 1'b0;
    end
    repeat (8) @(posedge sys_clk);
    link2.latch_enable_n <= 1'b1;
    link2.mosi <= ~w[32-n];
    repeat (16) @(posedge sys_clk);
  endtask
  task automatic t_reset();
    `CHK("irq", 1'b1, link.irq_out_n);
    rdreg(3'h2);
    `CHK("status", 28'h0, rd[31:4]);
    `CHK("sclk idle", 1'b0, link.serial_clock);
  endtask
  task automatic t_regs();
    wr(3'h5, 28'ha5c3e19);
    `CHK("mosi word", 32'ha5c3e195, last_w);
    wr(3'h4, 28'h0f0f0f0);
    rdreg(3'h5);
    `CHK("base5", 28'ha5c3e19, rd[31:4]);
    rdreg(3'h4);
    `CHK("base4", 28'h0f0f0f0, rd[31:4]);
  endtask
  task automatic t_abort();
    bb(32'h12345676, 32);
    bb(32'h76543216, 20);
    bb(32'h0000000e, 32);
    bb(32'h0, 32);
    `CHK("kept", 28'h1234567, got[31:4]);
    `CHK("released", 1'b1, link2.miso);
  endtask
  task automatic t_seq();
    wr(3'h1, 28'h8000000);
    wr(3'h3, 28'h4000000);
    wr(3'h3, 28'h1000000);
    `CHK("unknown", 1'b1, ref_unk);
    wr(3'h3, 28'h0800000);
    `CHK("rearmed", 1'b0, ref_unk);
    wr(3'h3, 28'h0);
    wr(3'h1, 28'h4000000);
    wr(3'h3, 28'h8000000);
    wr(3'h3, 28'h2000000);
    `CHK("div pulses", 1, n_div);
    wr(3'h1, 28'hc000000);
    rdreg(3'h1);
    `CHK("merged", 2'b01, rd[31:30]);
    wr(3'h1, 28'h8000000);
    wr(3'h3, 28'h4000000);
    wr(3'h3, 28'h1000000);
    `CHK("sync pulses", 1, n_sync);
    `CHK("pulses on", 1'b1, pulse_en);
    `CHK("div kept", 1, n_div);
  endtask
  task automatic t_status();
    cal <= 1'b1;
    wr(3'h2, 28'h3);
    ref_on <= 1'b1;
    repeat (100) @(posedge sys_clk);
    rdreg(3'h2);
    `CHK("flags", 3'b101, rd[30:28]);
    `CHK("sticky", 2'b01, rd[5:4]);
    `CHK("masked", 1'b1, link.irq_out_n);
    wr(3'h2, 28'h30);
    `CHK("irq on", 1'b0, link.irq_out_n);
    in_range <= 1'b1;
    repeat (5) @(posedge sys_clk);
    in_range <= 1'b0;
    rdreg(3'h2);
    `CHK("debounce", 1'b0, rd[29]);
    in_range <= 1'b1;
    repeat (30) @(posedge sys_clk);
    rdreg(3'h2);
    `CHK("lock", 2'b11, rd[30:29]);
    wr(3'h2, 28'h33);
    `CHK("irq off", 1'b1, link.irq_out_n);
    ref_on <= 1'b0;
    in_range <= 1'b0;
    repeat (100) @(posedge sys_clk);
    rdreg(3'h2);
    `CHK("lost", 5'b10011, {rd[30:28], rd[5:4]});
    ahb(1'b0, HOST_STAT, 32'h0);
    `CHK("pending", 1'b1, rd[1]);
  endtask
  initial begin
    link2.serial_clock = 1'b0;
    link2.latch_enable_n = 1'b1;
    link2.mosi = 1'b0;
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (2) @(posedge sys_clk);
    t_reset();
    t_regs();
    t_abort();
    t_seq();
    t_status();
    stop_test();
  end
endmodule
